// file: hdl/sleep_wake_pkg.sv
// constants and types for the sleep, wake and reset status block
package sleep_wake_pkg;
    // clock and watchdog timing
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int WDT_PERIOD_US = 18000;
    localparam int WDT_CYCLES = WDT_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int WDT_W = 19;
    // register word indices on the bus
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h1;
    localparam logic [3:0] REG_COMMAND = 4'h2;
    localparam logic [3:0] REG_PORT = 4'h3;
    localparam logic [3:0] REG_PORT_DIR = 4'h4;
    localparam logic [3:0] REG_COMP = 4'h5;
    // control bit positions and reset value
    localparam int CT_WDT_EN = 0;
    localparam int CT_MASTER_CLEAR_INPUT_EN = 1;
    localparam int CT_PIN_EN = 2;
    localparam int CT_COMP_EN = 3;
    localparam int CT_PROTECT = 4;
    localparam logic [4:0] CONTROL_RESET = 5'h03;
    // command bit positions
    localparam int CMD_SLEEP = 0;
    localparam int CMD_CLRWDT = 1;
    // synchroniser reset: master clear released, rest low
    localparam logic [7:0] SYNC_RESET = 8'h10;
    // serial programming
    localparam logic [3:0] PCMD_LAST = 4'h5;
    localparam logic [3:0] PDATA_LAST = 4'hD;
    localparam int PMEM_DEPTH = 1024;
    localparam int PADDR_W = 11;
    localparam int OPEN_WORDS = 64;
    localparam int ID_WORDS = 4;
    localparam logic [5:0] PCMD_LOAD = 6'h02;
    localparam logic [5:0] PCMD_READ = 6'h04;
    localparam logic [5:0] PCMD_INCR = 6'h06;
    // reset cause flags, bit 3 down to bit 0 in the status word
    typedef struct packed {
        logic comp_wake;
        logic pin_wake;
        logic time_out;
        logic power_down;
    } reset_flags_type;
    localparam reset_flags_type FLAGS_POWER_UP = 4'h3;
    // pin drive pair
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } port_drive_type;
    typedef enum logic [1:0] {
        PROG_OFF = 2'b00,
        PROG_CMD = 2'b01,
        PROG_LOAD = 2'b10,
        PROG_READ = 2'b11
    } prog_state_type;
endpackage : sleep_wake_pkg

// file: hdl/sleep_wake_reset_status.sv
// sleep control, wake sources, reset cause flags and serial programming
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// R1: sleep watchdog wake clears all four flags
// R2: awake watchdog clears time-out, wakes; keeps power-down
// R3: master clear wake: time-out set, others cleared
// R4: power-up sets power-down, time-out; clears wakes
// R5: awake master clear clears wakes only
// R6: pin wake sets pin flag, time-out; clears others
// R7: comparator wake sets its flag, time-out; clears others
// R8: sleep clears watchdog, sets time-out, clears power-down, stops oscillator
// R9: port pins hold their drive during sleep outside programming mode
// R10: watchdog reset never drives master clear
// R11: master clear or watchdog wakes; wake resets
// R12: enabled change on four port inputs wakes
// R13: enabled comparator output change wakes
// R14: pins compared against last port read or write
// R15: comparators compared against last config read
// R16: pin flag relative to last port operation
// R17: watchdog cleared on every wake
// R18: protection hides memory except first 64, last
// R19: four id words only in programming mode
// R20: programmer writes id upper bits as ones
// R21: programming entry: bits low, level raised
// R22: bit one clock, bit zero data
// R23: six-bit command then fourteen data bits
module sleep_wake_reset_status #(
    parameter int WDT_CYCLES = sleep_wake_pkg::WDT_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic [3:0] I_PORT_IN,
    output logic [3:0] O_PORT_OUT,
    output logic [3:0] O_PORT_OE,
    input wire logic I_MASTER_CLEAR_N,
    input wire logic I_HIGH_PROG_LEVEL,
    input wire logic [1:0] I_COMP_OUT,
    output logic O_DEVICE_RESET,
    output logic O_OSC_DRIVE_EN
);
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [3:0] port_s;
    logic master_clear_input_n_s;
    logic vpp_s;
    logic [1:0] comp_s;
    logic master_clear_input_prev_reg;
    logic vpp_prev_reg;
    logic pclk_prev_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] read_next;
    logic bus_take;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_port;
    logic wr_dir;
    logic rd_port;
    logic rd_comp;
    logic [4:0] ctrl_reg;
    logic [3:0] sw_out_reg;
    logic [3:0] sw_oe_reg;
    sleep_wake_pkg::port_drive_type drive_reg;
    sleep_wake_pkg::port_drive_type drive_next;
    sleep_wake_pkg::reset_flags_type flags_reg;
    logic asleep_reg;
    logic osc_reg;
    logic dev_rst_reg;
    logic [sleep_wake_pkg::WDT_W-1:0] wdt_count_reg;
    logic [3:0] port_snap_reg;
    logic [1:0] comp_snap_reg;
    logic in_prog;
    logic wdt_timeout;
    logic master_clear_input_evt;
    logic pin_change;
    logic comp_change;
    logic wake_master_clear_input;
    logic wake_wdt;
    logic wake_pin;
    logic wake_comp;
    logic wake_any;
    logic wdt_awake;
    logic master_clear_input_awake;
    logic sleep_go;
    logic clrwdt_cmd;
    sleep_wake_pkg::prog_state_type prog_state_reg;
    logic [3:0] pcnt_reg;
    logic [13:0] pshift_reg;
    logic [sleep_wake_pkg::PADDR_W-1:0] paddr_reg;
    logic pdrive_reg;
    logic pclk_rise;
    logic pdat_s;
    logic [5:0] pcmd;
    logic is_pmem;
    logic is_id;
    logic readable;
    logic [13:0] read_word;
    logic load_done;
    logic [13:0] pmem [0:sleep_wake_pkg::PMEM_DEPTH-1];
    logic [13:0] id_mem [0:sleep_wake_pkg::ID_WORDS-1];

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    // two-stage synchronisers for every pin input
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            sync1_reg <= sleep_wake_pkg::SYNC_RESET;
            sync2_reg <= sleep_wake_pkg::SYNC_RESET;
        end
        else
        begin
            sync1_reg <= {I_COMP_OUT, I_HIGH_PROG_LEVEL, I_MASTER_CLEAR_N,
                I_PORT_IN};
            sync2_reg <= sync1_reg;
        end
    end

    assign port_s = sync2_reg[3:0];
    assign master_clear_input_n_s = sync2_reg[4];
    assign vpp_s = sync2_reg[5];
    assign comp_s = sync2_reg[7:6];
    // R22: clock and data pins
    assign pclk_rise = port_s[1] & ~pclk_prev_reg;
    assign pdat_s = port_s[0];

    // previous values for edge detection
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            master_clear_input_prev_reg <= 1'b1;
            vpp_prev_reg <= 1'b0;
            pclk_prev_reg <= 1'b0;
        end
        else
        begin
            master_clear_input_prev_reg <= master_clear_input_n_s;
            vpp_prev_reg <= vpp_s;
            pclk_prev_reg <= port_s[1];
        end
    end

    // bus decode; a request is taken on the edge with waitrequest low
    assign bus_take = (I_AVS_READ | I_AVS_WRITE) & ~wait_reg;
    assign wr_ctrl = bus_take & I_AVS_WRITE
        & (I_AVS_ADDRESS == sleep_wake_pkg::REG_CONTROL);
    assign wr_cmd = bus_take & I_AVS_WRITE
        & (I_AVS_ADDRESS == sleep_wake_pkg::REG_COMMAND);
    assign wr_port = bus_take & I_AVS_WRITE
        & (I_AVS_ADDRESS == sleep_wake_pkg::REG_PORT);
    assign wr_dir = bus_take & I_AVS_WRITE
        & (I_AVS_ADDRESS == sleep_wake_pkg::REG_PORT_DIR);
    assign rd_port = bus_take & I_AVS_READ
        & (I_AVS_ADDRESS == sleep_wake_pkg::REG_PORT);
    assign rd_comp = bus_take & I_AVS_READ
        & (I_AVS_ADDRESS == sleep_wake_pkg::REG_COMP);

    // read data mux, unmapped words read zero
    always_comb
    begin
        read_next = 32'h0000_0000;
        unique case (I_AVS_ADDRESS)
            sleep_wake_pkg::REG_STATUS:
                read_next = {26'h0, in_prog, asleep_reg, flags_reg};
            sleep_wake_pkg::REG_CONTROL: read_next = {27'h0, ctrl_reg};
            sleep_wake_pkg::REG_PORT: read_next = {28'h0, port_s};
            sleep_wake_pkg::REG_PORT_DIR: read_next = {28'h0, sw_oe_reg};
            sleep_wake_pkg::REG_COMP: read_next = {30'h0, comp_s};
            default: read_next = 32'h0000_0000;
        endcase
    end

    // waitrequest: one wait cycle, then the answer stands one edge
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else if (bus_take)
            wait_reg <= 1'b1;
        else if (I_AVS_READ | I_AVS_WRITE)
        begin
            wait_reg <= 1'b0;
            rdata_reg <= read_next;
        end
    end

    // software control and port drive registers
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            ctrl_reg <= sleep_wake_pkg::CONTROL_RESET;
            sw_out_reg <= 4'h0;
            sw_oe_reg <= 4'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= I_AVS_WRITEDATA[4:0];
            // R9: port drive frozen while asleep
            if (wr_port && !asleep_reg)
                sw_out_reg <= I_AVS_WRITEDATA[3:0];
            if (wr_dir && !asleep_reg)
                sw_oe_reg <= I_AVS_WRITEDATA[3:0];
        end
    end

    // R14: snapshots of pins and comparators
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            port_snap_reg <= 4'h0;
            comp_snap_reg <= 2'h0;
        end
        else
        begin
            // R16: any port operation captures
            if (rd_port)
                port_snap_reg <= rdata_reg[3:0];
            else if (wr_port)
                port_snap_reg <= port_s;
            // R15: config read captures outputs
            if (rd_comp)
                comp_snap_reg <= rdata_reg[1:0];
        end
    end

    // event detection with priority master clear, watchdog, pin, comp
    assign in_prog = prog_state_reg != sleep_wake_pkg::PROG_OFF;
    assign wdt_timeout = ctrl_reg[sleep_wake_pkg::CT_WDT_EN] & ~in_prog
        & (wdt_count_reg == (sleep_wake_pkg::WDT_W)'(WDT_CYCLES - 1));
    assign master_clear_input_evt = ctrl_reg[sleep_wake_pkg::CT_MASTER_CLEAR_INPUT_EN] & ~in_prog
        & master_clear_input_prev_reg & ~master_clear_input_n_s;
    // R12: four monitored pins
    assign pin_change = ctrl_reg[sleep_wake_pkg::CT_PIN_EN]
        & (|(port_s ^ port_snap_reg));
    // R13: either comparator output
    assign comp_change = ctrl_reg[sleep_wake_pkg::CT_COMP_EN]
        & (|(comp_s ^ comp_snap_reg));
    // R11: master clear or watchdog wake
    assign wake_master_clear_input = asleep_reg & master_clear_input_evt;
    assign wake_wdt = asleep_reg & wdt_timeout & ~master_clear_input_evt;
    assign wake_pin = asleep_reg & ~in_prog & pin_change & ~master_clear_input_evt
        & ~wdt_timeout;
    assign wake_comp = asleep_reg & ~in_prog & comp_change & ~pin_change
        & ~master_clear_input_evt & ~wdt_timeout;
    assign wake_any = wake_master_clear_input | wake_wdt | wake_pin | wake_comp;
    assign wdt_awake = ~asleep_reg & wdt_timeout & ~master_clear_input_evt;
    assign master_clear_input_awake = ~asleep_reg & master_clear_input_evt;
    assign sleep_go = wr_cmd & I_AVS_WRITEDATA[sleep_wake_pkg::CMD_SLEEP]
        & ~asleep_reg & ~in_prog & ~wdt_awake & ~master_clear_input_awake;
    assign clrwdt_cmd = wr_cmd
        & I_AVS_WRITEDATA[sleep_wake_pkg::CMD_CLRWDT];

    // reset cause flags
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            // R4: power-up values
            flags_reg <= sleep_wake_pkg::FLAGS_POWER_UP;
        else if (wake_wdt)
            // R1: watchdog wake clears all
            flags_reg <= 4'h0;
        else if (wdt_awake)
            // R2: power-down kept
            flags_reg <= {3'h0, flags_reg.power_down};
        else if (wake_master_clear_input)
            // R3: master clear wake
            flags_reg <= 4'h2;
        else if (master_clear_input_awake)
            // R5: only wake flags cleared
            flags_reg <= {2'h0, flags_reg.time_out, flags_reg.power_down};
        else if (wake_pin)
            // R6: pin wake pattern
            flags_reg <= 4'h6;
        else if (wake_comp)
            // R7: comparator wake pattern
            flags_reg <= 4'hA;
        else if (sleep_go)
        begin
            // R8: sleep sets time-out, clears power-down
            flags_reg.time_out <= 1'b1;
            flags_reg.power_down <= 1'b0;
        end
    end

    // sleep state, oscillator driver and device reset pulse
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            asleep_reg <= 1'b0;
            osc_reg <= 1'b1;
            dev_rst_reg <= 1'b0;
        end
        else
        begin
            // R11: every wake ends in a device reset
            if (wake_any)
            begin
                asleep_reg <= 1'b0;
                osc_reg <= 1'b1;
            end
            else if (sleep_go)
            begin
                // R8: oscillator driver stopped
                asleep_reg <= 1'b1;
                osc_reg <= 1'b0;
            end
            // R10: reset is internal, master clear is input only
            dev_rst_reg <= wake_any | wdt_awake | master_clear_input_awake;
        end
    end

    // watchdog counter
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            wdt_count_reg <= '0;
        // R17: cleared on any wake
        else if (wake_any || sleep_go || clrwdt_cmd || wdt_timeout)
            wdt_count_reg <= '0;
        else if (!ctrl_reg[sleep_wake_pkg::CT_WDT_EN] || in_prog)
            wdt_count_reg <= '0;
        else
            wdt_count_reg <= wdt_count_reg + 1'b1;
    end

    // programming address decode and read protection
    assign pcmd = {pdat_s, pshift_reg[13:9]};
    assign is_pmem = paddr_reg < sleep_wake_pkg::PADDR_W'(
        sleep_wake_pkg::PMEM_DEPTH);
    // R19: id words above the program memory
    assign is_id = ~is_pmem & (paddr_reg < sleep_wake_pkg::PADDR_W'(
        sleep_wake_pkg::PMEM_DEPTH + sleep_wake_pkg::ID_WORDS));
    // R18: first words and last word always readable
    assign readable = ~ctrl_reg[sleep_wake_pkg::CT_PROTECT]
        | (paddr_reg < sleep_wake_pkg::PADDR_W'(sleep_wake_pkg::OPEN_WORDS))
        | (paddr_reg == sleep_wake_pkg::PADDR_W'(
            sleep_wake_pkg::PMEM_DEPTH - 1));

    always_comb
    begin
        read_word = 14'h0000;
        if (is_pmem && readable)
            read_word = pmem[paddr_reg[9:0]];
        else if (is_id)
            read_word = id_mem[paddr_reg[1:0]];
    end

    assign load_done = (prog_state_reg == sleep_wake_pkg::PROG_LOAD)
        & pclk_rise & (pcnt_reg == sleep_wake_pkg::PDATA_LAST);

    // serial programming engine
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST || !vpp_s)
        begin
            prog_state_reg <= sleep_wake_pkg::PROG_OFF;
            pcnt_reg <= 4'h0;
            pshift_reg <= 14'h0000;
            paddr_reg <= '0;
            pdrive_reg <= 1'b0;
        end
        else
        begin
            unique case (prog_state_reg)
                sleep_wake_pkg::PROG_OFF:
                    // R21: entry with clock and data low
                    if (vpp_s && !vpp_prev_reg && port_s[1:0] == 2'h0)
                    begin
                        prog_state_reg <= sleep_wake_pkg::PROG_CMD;
                        pcnt_reg <= 4'h0;
                        paddr_reg <= '0;
                    end
                sleep_wake_pkg::PROG_CMD:
                    // R23: six command bits, first bit lowest
                    if (pclk_rise)
                    begin
                        pshift_reg <= {pdat_s, pshift_reg[13:1]};
                        pcnt_reg <= pcnt_reg + 4'h1;
                        if (pcnt_reg == sleep_wake_pkg::PCMD_LAST)
                        begin
                            pcnt_reg <= 4'h0;
                            if (pcmd == sleep_wake_pkg::PCMD_LOAD)
                                prog_state_reg <= sleep_wake_pkg::PROG_LOAD;
                            else if (pcmd == sleep_wake_pkg::PCMD_READ)
                            begin
                                prog_state_reg <= sleep_wake_pkg::PROG_READ;
                                pshift_reg <= read_word;
                                pdrive_reg <= 1'b1;
                            end
                            else if (pcmd == sleep_wake_pkg::PCMD_INCR)
                                paddr_reg <= paddr_reg + 1'b1;
                        end
                    end
                sleep_wake_pkg::PROG_LOAD:
                    // R23: fourteen data bits in
                    if (pclk_rise)
                    begin
                        pshift_reg <= {pdat_s, pshift_reg[13:1]};
                        pcnt_reg <= pcnt_reg + 4'h1;
                        if (load_done)
                        begin
                            pcnt_reg <= 4'h0;
                            prog_state_reg <= sleep_wake_pkg::PROG_CMD;
                        end
                    end
                sleep_wake_pkg::PROG_READ:
                    // R23: fourteen data bits out
                    if (pclk_rise)
                    begin
                        pshift_reg <= {1'b0, pshift_reg[13:1]};
                        pcnt_reg <= pcnt_reg + 4'h1;
                        if (pcnt_reg == sleep_wake_pkg::PDATA_LAST)
                        begin
                            pcnt_reg <= 4'h0;
                            pdrive_reg <= 1'b0;
                            prog_state_reg <= sleep_wake_pkg::PROG_CMD;
                        end
                    end
            endcase
        end
    end

    // R19: memory and id writes only through programming
    always_ff @(posedge I_CLK)
    begin
        if (load_done && is_pmem)
            pmem[paddr_reg[9:0]] <= {pdat_s, pshift_reg[13:1]};
        else if (load_done && is_id)
            id_mem[paddr_reg[1:0]] <= {pdat_s, pshift_reg[13:1]};
    end

    // pin drive: programming takes bits zero and one
    always_comb
    begin
        drive_next.out = sw_out_reg;
        drive_next.oe = sw_oe_reg;
        if (in_prog)
        begin
            // R22: clock input, data two-way
            drive_next.out = {sw_out_reg[3:1], pshift_reg[0]};
            drive_next.oe = {sw_oe_reg[3:2], 1'b0, pdrive_reg};
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            drive_reg <= '0;
        else
            drive_reg <= drive_next;
    end

    assign O_AVS_READDATA = rdata_reg;
    assign O_AVS_WAITREQUEST = wait_reg;
    assign O_PORT_OUT = drive_reg.out;
    assign O_PORT_OE = drive_reg.oe;
    assign O_DEVICE_RESET = dev_rst_reg;
    assign O_OSC_DRIVE_EN = osc_reg;

    AST_WDT_SLEEP_WAKE: assert property ( // R1
        wake_wdt |=> flags_reg == 4'h0 && !asleep_reg)
        else $error("watchdog wake flags wrong");
    AST_WDT_AWAKE: assert property ( // R2
        wdt_awake |=> flags_reg[3:1] == 3'h0
            && flags_reg.power_down == $past(flags_reg.power_down))
        else $error("awake watchdog flags wrong");
    AST_MASTER_CLEAR_INPUT_WAKE: assert property ( // R3
        wake_master_clear_input |=> flags_reg == 4'h2 ##0 O_DEVICE_RESET)
        else $error("master clear wake flags wrong");
    AST_POWER_UP: assert property ( // R4
        $past(I_SYS_RST) |-> flags_reg == sleep_wake_pkg::FLAGS_POWER_UP)
        else $error("power-up flags wrong");
    AST_MASTER_CLEAR_INPUT_AWAKE: assert property ( // R5
        master_clear_input_awake |=> flags_reg[3:2] == 2'h0
            && flags_reg[1:0] == $past(flags_reg[1:0]))
        else $error("awake master clear flags wrong");
    AST_PIN_WAKE: assert property ( // R6
        wake_pin |=> flags_reg == 4'h6 && O_DEVICE_RESET && O_OSC_DRIVE_EN)
        else $error("pin wake flags wrong");
    AST_COMP_WAKE: assert property ( // R7
        wake_comp |=> flags_reg == 4'hA && O_DEVICE_RESET)
        else $error("comparator wake flags wrong");
    AST_SLEEP_ENTRY: assert property ( // R8
        sleep_go |=> asleep_reg && flags_reg.time_out
            && !flags_reg.power_down && wdt_count_reg == '0
            && !O_OSC_DRIVE_EN)
        else $error("sleep entry wrong");
    AST_PORT_HOLD: assert property ( // R9
        asleep_reg && $past(asleep_reg) && !in_prog && !$past(in_prog)
            |=> $stable(O_PORT_OUT) && $stable(O_PORT_OE))
        else $error("port drive moved in sleep");
    AST_PIN_SNAPSHOT: assert property ( // R14
        rd_port |=> port_snap_reg == $past(O_AVS_READDATA[3:0]))
        else $error("pin snapshot not taken");
    AST_WAKE_WDT_CLEAR: assert property ( // R17
        wake_any |=> wdt_count_reg == '0 && !asleep_reg)
        else $error("watchdog not cleared on wake");
    AST_PROTECT: assert property ( // R18
        prog_state_reg == sleep_wake_pkg::PROG_CMD && pclk_rise
            && pcnt_reg == sleep_wake_pkg::PCMD_LAST
            && pcmd == sleep_wake_pkg::PCMD_READ && !readable && !is_id
            |=> pshift_reg == 14'h0000 && pdrive_reg)
        else $error("protected word leaked");
endmodule : sleep_wake_reset_status

// file: tb/prog_partner.sv
// serial programmer and wake pin source model
`timescale 1ns/1ps
module prog_partner (
    input wire logic i_clk,
    input wire logic i_data_line,
    output logic [3:0] o_pins,
    output logic o_level
);
    initial
    begin
        o_pins = 4'h0;
        o_level = 1'h0;
    end
    task automatic drive(input logic [3:0] p, input logic l);
        o_pins <= p;
        o_level <= l;
    endtask : drive
    // shift n bits lsb first, clock idles low
    task automatic shift(input int n, input logic [13:0] d,
        output logic [13:0] q);
        q = 14'h0;
        for (int i = 0; i < n; i++)
        begin
            o_pins[0] <= d[i];
            repeat (4) @(posedge i_clk);
            q[i] = i_data_line;
            o_pins[1] <= 1'h1;
            repeat (4) @(posedge i_clk);
            o_pins[1] <= 1'h0;
        end
    endtask : shift
    // id word: data in low bits, ones above
    task automatic load_id(input logic [3:0] v);
        logic [13:0] unused;
        shift(14, {10'h3FF, v}, unused);
    endtask : load_id
endmodule : prog_partner

// file: tb/sleep_wake_reset_status_bench.sv
// bench for the sleep, wake and reset status block
`timescale 1ns/1ps
module sleep_wake_reset_status_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, v;
    logic wait_req, dev_rst, osc, level;
    logic [3:0] pout, poe, pins, pin_in;
    logic master_clear_input_n = 1'h1;
    logic [1:0] comp = 2'h0;
    logic [13:0] q;
    int error_cnt = 0;
    int n_checks = 0;
    // clock and resolved pin levels, device drive wins
    always #25 clk = ~clk;
    assign pin_in = (poe & pout) | (~poe & pins);
    sleep_wake_reset_status #(.WDT_CYCLES(64)) u_dut (.I_CLK(clk),
        .I_SYS_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wait_req), .I_PORT_IN(pin_in),
        .O_PORT_OUT(pout), .O_PORT_OE(poe), .I_MASTER_CLEAR_N(master_clear_input_n),
        .I_HIGH_PROG_LEVEL(level), .I_COMP_OUT(comp),
        .O_DEVICE_RESET(dev_rst), .O_OSC_DRIVE_EN(osc));
    prog_partner u_prog (.i_clk(clk), .i_data_line(pin_in[0]),
        .o_pins(pins), .o_level(level));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk);
            if (wait_req === 1'h0)
                break;
        end
        v = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
        if (k == 40)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask : bus
    task automatic st(input logic [31:0] e);
        bus(1'h0, sleep_wake_pkg::REG_STATUS, 32'h0);
        chk("status", e, v);
    endtask : st
    task automatic nap;
        bus(1'h1, sleep_wake_pkg::REG_COMMAND, 32'h1);
    endtask : nap
    // bounded wait for the reset pulse
    task automatic wake_wait;
        for (int k = 0; k < 200; k++)
        begin
            @(posedge clk);
            if (dev_rst === 1'h1)
                return;
        end
        error_cnt++;
        report_and_stop();
    endtask : wake_wait
    task automatic t_sleep_master_clear_input;
        bus(1'h1, sleep_wake_pkg::REG_CONTROL, 32'h2);
        nap();
        st(32'h12);
        chk("osc", 32'h0, {31'h0, osc});
        master_clear_input_n <= 1'h0;
        wake_wait();
        master_clear_input_n <= 1'h1;
        st(32'h2);
    endtask : t_sleep_master_clear_input
    task automatic t_pin_wake;
        bus(1'h1, sleep_wake_pkg::REG_PORT_DIR, 32'h4);
        bus(1'h1, sleep_wake_pkg::REG_PORT, 32'h4);
        bus(1'h1, sleep_wake_pkg::REG_CONTROL, 32'h6);
        bus(1'h0, sleep_wake_pkg::REG_PORT, 32'h0);
        nap();
        bus(1'h1, sleep_wake_pkg::REG_PORT, 32'h0);
        chk("port", 32'h44, {24'h0, poe, pout});
        u_prog.drive(4'h8, 1'h0);
        wake_wait();
        st(32'h6);
        master_clear_input_n <= 1'h0;
        wake_wait();
        master_clear_input_n <= 1'h1;
        st(32'h2);
    endtask : t_pin_wake
    task automatic t_comp_wake;
        bus(1'h1, sleep_wake_pkg::REG_CONTROL, 32'hA);
        bus(1'h0, sleep_wake_pkg::REG_COMP, 32'h0);
        nap();
        comp <= 2'h2;
        wake_wait();
        st(32'hA);
    endtask : t_comp_wake
    task automatic t_sleep_wdt;
        bus(1'h1, sleep_wake_pkg::REG_CONTROL, 32'h3);
        bus(1'h1, sleep_wake_pkg::REG_COMMAND, 32'h2);
        nap();
        wake_wait();
        st(32'h0);
        bus(1'h1, sleep_wake_pkg::REG_CONTROL, 32'h0);
    endtask : t_sleep_wdt
    task automatic t_program;
        u_prog.drive(4'h0, 1'h1);
        repeat (8) @(posedge clk);
        bus(1'h0, sleep_wake_pkg::REG_STATUS, 32'h0);
        chk("prog mode", 32'h20, v);
        u_prog.shift(6, 14'h02, q);
        u_prog.shift(14, 14'h2A5C, q);
        u_prog.shift(6, 14'h04, q);
        u_prog.shift(14, 14'h0, q);
        chk("read word", 32'h2A5C, {18'h0, q});
        bus(1'h1, sleep_wake_pkg::REG_CONTROL, 32'h10);
        u_prog.shift(6, 14'h04, q);
        u_prog.shift(14, 14'h0, q);
        chk("open word", 32'h2A5C, {18'h0, q});
        repeat (64) u_prog.shift(6, 14'h06, q);
        u_prog.shift(6, 14'h04, q);
        u_prog.shift(14, 14'h0, q);
        chk("hidden word", 32'h0, {18'h0, q});
        repeat (960) u_prog.shift(6, 14'h06, q);
        u_prog.shift(6, 14'h02, q);
        u_prog.load_id(4'h5);
        u_prog.shift(6, 14'h04, q);
        u_prog.shift(14, 14'h0, q);
        chk("id word", 32'h3FF5, {18'h0, q});
        u_prog.drive(4'h0, 1'h0);
    endtask : t_program
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        st(32'h3);
        wake_wait();
        st(32'h1);
        t_sleep_master_clear_input();
        t_pin_wake();
        t_comp_wake();
        t_sleep_wdt();
        t_program();
        report_and_stop();
    end
endmodule : sleep_wake_reset_status_bench
